// ---- interrupt_arbiter_pkg.sv ----
// package for the priority interrupt arbiter: register indices, field layout,
// reset values and the winner carrier.
// assumes a 32-bit APB slave where each register index takes one aligned word.
package interrupt_arbiter_pkg;
	localparam int NUM_SRC      = 82;
	localparam int VEC_W        = 7;
	localparam int VBA_W        = 14;
	localparam int LOW_W        = 16;
	localparam int HIGH_W       = 5;
	localparam int ADDR_W       = VBA_W + VEC_W;
	localparam int FIELD_W      = 4;
	localparam int SRC_PER_REG  = 8;
	localparam int PRI_REGS     = 10;
	localparam int FIRST_PROG   = 2;
	localparam int PEND_REGS    = 6;
	localparam int PEND_W       = 16;
	localparam int SRC_EXT_A    = 2;
	localparam int SRC_EXT_B    = 3;
	localparam int EVT_W        = 3;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_PRIORITY0  = 6'h00;
	localparam logic [5:0] IDX_VECTOR_BASE = 6'h0A;
	localparam logic [5:0] IDX_FAST_MATCH0 = 6'h0B;
	localparam logic [5:0] IDX_FAST_LOW0  = 6'h0C;
	localparam logic [5:0] IDX_FAST_HIGH0 = 6'h0D;
	localparam logic [5:0] IDX_FAST_MATCH1 = 6'h0E;
	localparam logic [5:0] IDX_FAST_LOW1  = 6'h0F;
	localparam logic [5:0] IDX_FAST_HIGH1 = 6'h10;
	localparam logic [5:0] IDX_PENDING0   = 6'h11;
	localparam logic [5:0] IDX_CONTROL    = 6'h18;
	localparam logic [5:0] IDX_STATUS     = 6'h19;
	localparam logic [5:0] IDX_MASK       = 6'h1A;

	// priority field: bits 1:0 level, bit 2 enable
	localparam int FLD_ENABLE  = 2;
	localparam int CTL_EDGE_A  = 0;
	localparam int CTL_EDGE_B  = 1;
	localparam int ST_FAST0    = 0;
	localparam int ST_FAST1    = 1;
	localparam int ST_WAKE     = 2;

	localparam logic [1:0] FIXED_LEVEL = 2'h3;
	localparam logic [1:0] FAST_LEVEL  = 2'h2;
	localparam logic [1:0] CODE_NONE   = 2'h0;
	localparam logic [1:0] CODE_P0     = 2'h1;
	localparam logic [1:0] CODE_P1     = 2'h2;
	localparam logic [1:0] CODE_P23    = 2'h3;
	localparam logic [ADDR_W-1:0] RESET_ADDRESS = 21'h000000;

	typedef struct packed {
		logic             found;
		logic [1:0]       level;
		logic [VEC_W-1:0] vec;
	} winner_s;

	typedef enum logic [0:0] {
		PH_BOOT = 1'b0,
		PH_RUN  = 1'b1
	} phase_e;
endpackage

// ---- interrupt_arbiter.sv ----
// priority interrupt arbiter: per-source levels, per-level encoder, vector
// generation with two fast slots, wake request, APB register slave.
// assumes sources and core signals share pclk; external irq pins are async.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - arbitrate pending requests, signal the core, supply service address
// - 82 sources, each programmable one of four levels except fixed ones
// - within a level the lowest-numbered active source wins
// - normal vector is vector base concatenated with vector number
// - core mask 00..11 permits levels from that value upward
// - current level code 00,01,10,11 sets the nesting threshold
// - fast only when winner matches a slot and is at level 2
// - fast vector address comes from the matching slot low and high
// - two independent fast slots each with match and address pair
// - fast decision made before the core fetches
// - notify integration unit to restart clocks on serviceable request; code wakes on any active source enabled at entry, ignoring mask and level
// - drive the initial program address after reset
// - registers reachable as a slave on the peripheral bus
// - in low power only sources enabled before entry may wake
// - in low power external irqs act as low-level sensitive
module interrupt_arbiter
	import interrupt_arbiter_pkg::*;
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output var  logic [31:0]        prdata,
	output var  logic               pready,
	output var  logic               pslverr,
	input  wire logic [NUM_SRC-1:0] irq_src,
	input  wire logic               external_irq_a_n,
	input  wire logic               external_irq_b_n,
	input  wire logic [1:0]         core_mask_status,
	input  wire logic               core_ack,
	input  wire logic               core_return,
	input  wire logic               low_power,
	input  wire logic               boot_fetched,
	output var  logic               irq_request,
	output var  logic [ADDR_W-1:0]  vector_address,
	output var  logic               fast_irq,
	output var  logic [1:0]         current_level_code,
	output var  logic               wake_request,
	output var  logic               boot_drive,
	output var  logic               irq
);
	logic [SRC_PER_REG*FIELD_W-1:0] priority_assign_regs [PRI_REGS];
	logic [VBA_W-1:0]  vector_base;
	logic [VEC_W-1:0]  fast_match_slot0;
	logic [VEC_W-1:0]  fast_match_slot1;
	logic [LOW_W-1:0]  fast_vector_low [2];
	logic [HIGH_W-1:0] fast_vector_high [2];
	logic [1:0]        control;
	logic [EVT_W-1:0]  status;
	logic [EVT_W-1:0]  mask;
	logic [EVT_W-1:0]  read_taken;

	logic [NUM_SRC-1:0] active;
	logic [NUM_SRC-1:0] enabled;
	logic [NUM_SRC-1:0] en_snap;
	logic [1:0]         level [NUM_SRC];
	logic [2:0]         sync_a;
	logic [2:0]         sync_b;
	logic               ext_a;
	logic               ext_b;
	logic               latch_a;
	logic               latch_b;
	logic               lp_prev;
	winner_s            win;
	winner_s            win_q;
	logic [1:0]         threshold;
	logic               hit0;
	logic               hit1;
	logic               fast_now;
	logic               slot_q;
	phase_e             phase;
	logic [5:0]         idx;
	logic               mapped;
	logic [31:0]        rdata;
	logic               access;
	logic [EVT_W-1:0]   events;
	logic               any_wake;

	assign idx    = paddr[7:2];
	assign access = psel & penable & pready;

	// per-source level and enable
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++)
		begin : g_src
			if (g < FIRST_PROG)
			begin : g_fixed
				assign level[g]   = FIXED_LEVEL;
				assign enabled[g] = 1'b1;
			end
			else
			begin : g_prog
				localparam int R = (g - FIRST_PROG) / SRC_PER_REG;
				localparam int F = ((g - FIRST_PROG) % SRC_PER_REG) * FIELD_W;
				assign level[g]   = priority_assign_regs[R][F +: 2];
				assign enabled[g] = priority_assign_regs[R][F + FLD_ENABLE];
			end
		end
	endgenerate

	// external pins: three flops, a change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_a <= 3'h7;
			sync_b <= 3'h7;
			ext_a  <= 1'b1;
			ext_b  <= 1'b1;
		end
		else
		begin
			sync_a <= {sync_a[1:0], external_irq_a_n};
			sync_b <= {sync_b[1:0], external_irq_b_n};
			if (sync_a[1] == sync_a[2])
				ext_a <= sync_a[2];
			if (sync_b[1] == sync_b[2])
				ext_b <= sync_b[2];
		end
	end

	// falling-edge latches; a new edge wins over the acknowledge clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			latch_a <= 1'b0;
			latch_b <= 1'b0;
		end
		else
		begin
			if (ext_a && sync_a[1] == sync_a[2] && !sync_a[2])
				latch_a <= 1'b1;
			else if (core_ack && win_q.vec == VEC_W'(SRC_EXT_A))
				latch_a <= 1'b0;
			if (ext_b && sync_b[1] == sync_b[2] && !sync_b[2])
				latch_b <= 1'b1;
			else if (core_ack && win_q.vec == VEC_W'(SRC_EXT_B))
				latch_b <= 1'b0;
		end
	end

	// low power has no clock for edges, so pins fall back to low level
	always_comb
	begin
		active = irq_src;
		active[SRC_EXT_A] = (control[CTL_EDGE_A] && !low_power) ? latch_a : !ext_a;
		active[SRC_EXT_B] = (control[CTL_EDGE_B] && !low_power) ? latch_b : !ext_b;
	end

	// nesting threshold: the code's value equals the lowest level it admits
	assign threshold = (core_mask_status > current_level_code) ? core_mask_status
	                 : current_level_code;

	// walk from the top so the lowest number is the last to be taken
	always_comb
	begin
		win = '0;
		for (int l = 0; l < 4; l++)
		begin
			if (2'(l) >= threshold)
			begin
				for (int i = NUM_SRC - 1; i >= 0; i--)
				begin
					if (active[i] && enabled[i] && level[i] == 2'(l))
					begin
						win.found = 1'b1;
						win.level = 2'(l);
						win.vec   = VEC_W'(i);
					end
				end
			end
		end
	end

	assign hit0     = win.vec == fast_match_slot0;
	assign hit1     = win.vec == fast_match_slot1;
	assign fast_now = win.found && win.level == FAST_LEVEL && (hit0 || hit1);

	// vector is registered in the same cycle as the request, before any fetch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_request    <= 1'b0;
			vector_address <= RESET_ADDRESS;
			fast_irq       <= 1'b0;
			win_q          <= '0;
			slot_q         <= 1'b0;
		end
		else if (phase == PH_BOOT)
			vector_address <= RESET_ADDRESS;
		else
		begin
			irq_request <= win.found;
			win_q       <= win;
			fast_irq    <= fast_now;
			slot_q      <= !hit0;
			if (fast_now)
				vector_address <= hit0 ? {fast_vector_high[0], fast_vector_low[0]}
				                       : {fast_vector_high[1], fast_vector_low[1]};
			else
				vector_address <= {vector_base, win.vec};
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase <= PH_BOOT;
		else if (boot_fetched)
			phase <= PH_RUN;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			boot_drive <= 1'b1;
		else
			boot_drive <= (phase == PH_BOOT) && !boot_fetched;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			current_level_code <= CODE_NONE;
		else if (core_ack && irq_request)
		begin
			case (win_q.level)
				2'h0:    current_level_code <= CODE_P0;
				2'h1:    current_level_code <= CODE_P1;
				default: current_level_code <= CODE_P23;
			endcase
		end
		else if (core_return)
			current_level_code <= CODE_NONE;
	end

	// enables are frozen on entry; later enables cannot wake the core
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lp_prev <= 1'b0;
			en_snap <= '0;
		end
		else
		begin
			lp_prev <= low_power;
			if (low_power && !lp_prev)
				en_snap <= enabled;
		end
	end

	assign any_wake = |(active & en_snap);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_request <= 1'b0;
		else
			wake_request <= low_power && lp_prev && any_wake;
	end

	assign events = {low_power && lp_prev && any_wake && !wake_request,
	                 core_ack && fast_irq && slot_q,
	                 core_ack && fast_irq && !slot_q};

	// only bits that were read are cleared, and a new event still wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status <= '0;
		else if (access && !pwrite && idx == IDX_STATUS)
			status <= (status & ~read_taken) | events;
		else
			status <= status | events;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |((status | events) & mask);
	end

	always_comb
	begin
		mapped = (idx <= IDX_FAST_HIGH1) || (idx >= IDX_PENDING0
		         && idx < IDX_PENDING0 + 6'(PEND_REGS))
		         || (idx >= IDX_CONTROL && idx <= IDX_MASK);
		rdata = '0;
		if (idx < IDX_VECTOR_BASE)
			rdata = priority_assign_regs[idx[3:0]];
		else if (idx >= IDX_PENDING0 && idx < IDX_PENDING0 + 6'(PEND_REGS))
			rdata[PEND_W-1:0] = 16'({14'h0000, active} >> (PEND_W * (idx - IDX_PENDING0)));
		else
		begin
			case (idx)
				IDX_VECTOR_BASE: rdata[VBA_W-1:0]  = vector_base;
				IDX_FAST_MATCH0: rdata[VEC_W-1:0]  = fast_match_slot0;
				IDX_FAST_LOW0:   rdata[LOW_W-1:0]  = fast_vector_low[0];
				IDX_FAST_HIGH0:  rdata[HIGH_W-1:0] = fast_vector_high[0];
				IDX_FAST_MATCH1: rdata[VEC_W-1:0]  = fast_match_slot1;
				IDX_FAST_LOW1:   rdata[LOW_W-1:0]  = fast_vector_low[1];
				IDX_FAST_HIGH1:  rdata[HIGH_W-1:0] = fast_vector_high[1];
				IDX_CONTROL:     rdata[3:0]        = {current_level_code, control};
				IDX_STATUS:      rdata[EVT_W-1:0]  = status;
				IDX_MASK:        rdata[EVT_W-1:0]  = mask;
				default:         rdata = '0;
			endcase
		end
	end

	// answer one cycle after setup, so every access has one wait-free cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready     <= 1'b0;
			prdata     <= '0;
			pslverr    <= 1'b0;
			read_taken <= '0;
		end
		else
		begin
			pready <= psel && !penable;
			if (psel && !penable)
			begin
				prdata     <= pwrite ? 32'h00000000 : rdata;
				pslverr    <= !mapped;
				read_taken <= status;
			end
			else
				pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int r = 0; r < PRI_REGS; r++)
				priority_assign_regs[r] <= '0;
			vector_base         <= '0;
			fast_match_slot0    <= '0;
			fast_match_slot1    <= '0;
			fast_vector_low[0]  <= '0;
			fast_vector_low[1]  <= '0;
			fast_vector_high[0] <= '0;
			fast_vector_high[1] <= '0;
			control             <= '0;
			mask                <= '0;
		end
		else if (access && pwrite)
		begin
			if (idx < IDX_VECTOR_BASE)
				priority_assign_regs[idx[3:0]] <= pwdata;
			case (idx)
				IDX_VECTOR_BASE: vector_base         <= pwdata[VBA_W-1:0];
				IDX_FAST_MATCH0: fast_match_slot0    <= pwdata[VEC_W-1:0];
				IDX_FAST_LOW0:   fast_vector_low[0]  <= pwdata[LOW_W-1:0];
				IDX_FAST_HIGH0:  fast_vector_high[0] <= pwdata[HIGH_W-1:0];
				IDX_FAST_MATCH1: fast_match_slot1    <= pwdata[VEC_W-1:0];
				IDX_FAST_LOW1:   fast_vector_low[1]  <= pwdata[LOW_W-1:0];
				IDX_FAST_HIGH1:  fast_vector_high[1] <= pwdata[HIGH_W-1:0];
				IDX_CONTROL:     control             <= pwdata[1:0];
				IDX_MASK:        mask                <= pwdata[EVT_W-1:0];
				default:         control             <= control;
			endcase
		end
	end
endmodule

`default_nettype wire

// ---- interrupt_arbiter_asserts.sv ----
// port checker for the priority interrupt arbiter
// assumes one pclk domain and presetn asynchronous, active low
`timescale 1ns/1ps
`default_nettype none
module interrupt_arbiter_asserts
	import interrupt_arbiter_pkg::*;
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [1:0]        core_mask_status,
	input wire logic              core_ack,
	input wire logic              core_return,
	input wire logic              low_power,
	input wire logic              irq_request,
	input wire logic [ADDR_W-1:0] vector_address,
	input wire logic              fast_irq,
	input wire logic [1:0]        current_level_code,
	input wire logic              wake_request,
	input wire logic              boot_drive
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_boot_addr: assert property (boot_drive |-> vector_address == RESET_ADDRESS)
		else $error("boot address wrong");
	a_boot_quiet: assert property (boot_drive |-> !irq_request && !fast_irq)
		else $error("request during boot");
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_fast_level: assert property (fast_irq |-> irq_request && $past(core_mask_status) != 2'h3)
		else $error("fast flag above level two");
	a_ack_code: assert property (core_ack && irq_request && !core_return |=> current_level_code != CODE_NONE)
		else $error("level code not set by ack");
	a_return_clear: assert property (core_return && !core_ack |=> current_level_code == CODE_NONE)
		else $error("level code not cleared");
	a_wake_cause: assert property (wake_request |-> $past(low_power))
		else $error("wake outside low power");
	a_wake_entry: assert property ($rose(low_power) |=> !wake_request)
		else $error("wake too early");
endmodule
bind interrupt_arbiter interrupt_arbiter_asserts interrupt_arbiter_asserts_inst (.pclk, .presetn,
	.psel, .penable, .pready, .pslverr, .core_mask_status, .core_ack, .core_return, .low_power,
	.irq_request, .vector_address, .fast_irq, .current_level_code, .wake_request, .boot_drive);
`default_nettype wire

// ---- core_model.sv ----
// behavioural core facing the arbiter: boot fetch, acknowledge, return
// assumes pclk domain; mask, ack delay and return come from the bench
`timescale 1ns/1ps
`default_nettype none
module core_model
	import interrupt_arbiter_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              boot_drive,
	input  wire logic              irq_request,
	input  wire logic [ADDR_W-1:0] vector_address,
	input  wire logic              fast_irq,
	input  wire logic [1:0]        mask_cfg,
	input  wire logic [3:0]        ack_delay,
	input  wire logic              ret_req,
	output var  logic [1:0]        core_mask_status,
	output var  logic              core_ack,
	output var  logic              core_return,
	output var  logic              boot_fetched,
	output var  logic [ADDR_W-1:0] taken_addr,
	output var  logic              taken_fast
);
	logic       busy;
	logic [3:0] wait_cnt;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_mask_status <= 2'h0;
			core_ack         <= 1'b0;
			core_return      <= 1'b0;
			boot_fetched     <= 1'b0;
			taken_addr       <= '0;
			taken_fast       <= 1'b0;
			busy             <= 1'b0;
			wait_cnt         <= 4'h0;
		end
		else
		begin
			core_mask_status <= mask_cfg;
			boot_fetched     <= boot_drive && !boot_fetched;
			core_return      <= ret_req;
			core_ack         <= 1'b0;
			if (ret_req)
				busy <= 1'b0;
			if (!irq_request || busy)
				wait_cnt <= 4'h0;
			else if (wait_cnt != ack_delay)
				wait_cnt <= wait_cnt + 4'h1;
			else
			begin
				// one take per service; nesting is left to the bench
				core_ack   <= 1'b1;
				busy       <= 1'b1;
				taken_addr <= vector_address;
				taken_fast <= fast_irq;
				wait_cnt   <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- test_priority_interrupt_arbiter.sv ----
// self-checking bench for the interrupt arbiter with a behavioural core
// assumes one 20 MHz clock; external irq pins idle high between pulses
`timescale 1ns/1ps
`default_nettype none
module test_priority_interrupt_arbiter
	import interrupt_arbiter_pkg::*;
;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic [NUM_SRC-1:0] irq_src;
	logic [1:0]         mask_cfg, core_mask_status, current_level_code;
	logic [3:0]         ack_delay;
	logic               low_power, ret_req, core_ack, core_return, boot_fetched, irq_request;
	logic               fast_irq, wake_request, boot_drive, irq, taken_fast;
	logic [ADDR_W-1:0]  vector_address, taken_addr;
	logic [31:0]        pri [PRI_REGS];
	logic               ext_a_n, ext_b_n;
	int                 miscompares, check_count, cycles;
	int                 lvl_src [4] = '{30, 5, 40, 0};

	interrupt_arbiter interrupt_arbiter_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .irq_src, .external_irq_a_n(ext_a_n),
		.external_irq_b_n(ext_b_n), .core_mask_status, .core_ack, .core_return, .low_power,
		.boot_fetched, .irq_request, .vector_address, .fast_irq, .current_level_code,
		.wake_request, .boot_drive, .irq);
	core_model core_model_inst (.pclk, .presetn, .boot_drive, .irq_request, .vector_address,
		.fast_irq, .mask_cfg, .ack_delay, .ret_req, .core_mask_status, .core_ack, .core_return,
		.boot_fetched, .taken_addr, .taken_fast);

	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// generous ceiling; the whole sequence needs well under a thousand cycles
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			stop_test();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// sources 0 and 1 have fixed levels, so the first field belongs to source 2
	task automatic set_src(input int s, input logic [1:0] lvl, input logic en);
		pri[(s - FIRST_PROG) / SRC_PER_REG][FIELD_W * ((s - FIRST_PROG) % SRC_PER_REG) +: 4]
			= {1'b0, en, lvl};
		apb(1'b1, 6'((s - FIRST_PROG) / SRC_PER_REG), pri[(s - FIRST_PROG) / SRC_PER_REG]);
	endtask

	// raise sources, wait for the take, judge address, fast flag and level code
	task automatic serve(input logic [NUM_SRC-1:0] srcs, input logic [ADDR_W-1:0] exp_addr,
		input logic exp_fast, input logic [1:0] exp_code, input logic [3:0] dly);
		int n;
		n = 0;
		ack_delay <= dly;
		irq_src   <= srcs;
		@(posedge pclk);
		while (core_ack !== 1'b1 && n < 40)
		begin
			@(posedge pclk);
			n++;
		end
		check(n < 40, 1'b1);
		@(negedge pclk);
		check(taken_addr, exp_addr);
		check(taken_fast, exp_fast);
		check(current_level_code, exp_code);
		@(posedge pclk);
		irq_src <= '0;
		ret_req <= 1'b1;
		@(posedge pclk);
		ret_req <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	task automatic t_regs();
		apb(1'b1, IDX_VECTOR_BASE, 32'h000002A5);
		apb(1'b0, IDX_VECTOR_BASE, 32'h0);
		check(rd, 32'h000002A5);
		apb(1'b1, 6'h17, 32'hFFFFFFFF);
		check(err, 1'b1);
		apb(1'b0, 6'h17, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, IDX_FAST_MATCH0, 32'h14);
		apb(1'b1, IDX_FAST_LOW0, 32'hBEEF);
		apb(1'b1, IDX_FAST_HIGH0, 32'h15);
		apb(1'b1, IDX_FAST_MATCH1, 32'h15);
		apb(1'b1, IDX_FAST_LOW1, 32'h1234);
		apb(1'b1, IDX_FAST_HIGH1, 32'h0A);
		apb(1'b1, IDX_MASK, 32'h1);
	endtask

	task automatic t_arb();
		set_src(5, 2'h1, 1'b1);
		set_src(9, 2'h1, 1'b1);
		set_src(30, 2'h0, 1'b1);
		set_src(20, 2'h2, 1'b1);
		set_src(21, 2'h2, 1'b1);
		set_src(40, 2'h2, 1'b1);
		serve(82'h1 << 5 | 82'h1 << 9, {14'h2A5, 7'h05}, 1'b0, CODE_P1, 4'h0);
		serve(82'h1 << 30, {14'h2A5, 7'h1E}, 1'b0, CODE_P0, 4'h2);
		serve(82'h1, {14'h2A5, 7'h00}, 1'b0, CODE_P23, 4'h5);
		serve(82'h1 << 40, {14'h2A5, 7'h28}, 1'b0, CODE_P23, 4'h0);
		serve(82'h1 << 20, {5'h15, 16'hBEEF}, 1'b1, CODE_P23, 4'h1);
		check(irq, 1'b1);
		apb(1'b0, IDX_STATUS, 32'h0);
		check(rd[2:0], 3'h1);
		@(negedge pclk);
		check(irq, 1'b0);
		@(posedge pclk);
		serve(82'h1 << 21, {5'h0A, 16'h1234}, 1'b1, CODE_P23, 4'h0);
		check(irq, 1'b0);
	endtask

	task automatic t_mask();
		ack_delay <= 4'hF;
		for (int m = 0; m < 4; m++)
			for (int l = 0; l < 4; l++)
			begin
				mask_cfg <= 2'(m);
				irq_src  <= 82'h1 << lvl_src[l];
				repeat (4) @(posedge pclk);
				check(irq_request, l >= m);
				irq_src <= '0;
				repeat (3) @(posedge pclk);
			end
		mask_cfg <= 2'h0;
	endtask

	task automatic t_wake();
		// mask 3 keeps the core from taking the level 1 sources here
		mask_cfg  <= 2'h3;
		low_power <= 1'b1;
		repeat (4) @(posedge pclk);
		set_src(60, 2'h1, 1'b1);
		irq_src <= 82'h1 << 60;
		repeat (6) @(posedge pclk);
		check(wake_request, 1'b0);
		irq_src <= 82'h1 << 5;
		repeat (6) @(posedge pclk);
		check(wake_request, 1'b1);
		irq_src   <= '0;
		low_power <= 1'b0;
		mask_cfg  <= 2'h0;
		repeat (4) @(posedge pclk);
		apb(1'b0, IDX_STATUS, 32'h0);
		check(rd[2:0], 3'h6);
	endtask

	// pin a latched on its falling edge in run mode; in low power both pins act by level
	task automatic t_ext();
		ack_delay <= 4'hF;
		set_src(2, 2'h1, 1'b1);
		set_src(3, 2'h1, 1'b1);
		apb(1'b1, IDX_CONTROL, 32'h1);
		ext_a_n <= 1'b0;
		repeat (3) @(posedge pclk);
		ext_a_n <= 1'b1;
		repeat (8) @(posedge pclk);
		check(irq_request, 1'b1);
		serve('0, {14'h2A5, 7'h02}, 1'b0, CODE_P1, 4'h0);
		mask_cfg  <= 2'h3;
		low_power <= 1'b1;
		repeat (2) @(posedge pclk);
		ext_a_n <= 1'b0;
		repeat (8) @(posedge pclk);
		check(wake_request, 1'b1);
		ext_a_n <= 1'b1;
		ext_b_n <= 1'b0;
		repeat (8) @(posedge pclk);
		check(wake_request, 1'b1);
		ext_b_n <= 1'b1;
		repeat (8) @(posedge pclk);
		// edge mode on pin a must not keep the wake alive once the pin is high
		check(wake_request, 1'b0);
		low_power <= 1'b0;
		mask_cfg  <= 2'h0;
		serve('0, {14'h2A5, 7'h02}, 1'b0, CODE_P1, 4'h0);
		check(irq_request, 1'b0);
	endtask

	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, low_power, ret_req} = '0;
		{paddr, pwdata, irq_src, mask_cfg, ack_delay} = '0;
		{miscompares, check_count, cycles} = '0;
		{ext_a_n, ext_b_n} = 2'h3;
		pri = '{default: 32'h0};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check(boot_drive, 1'b1);
		check(vector_address, RESET_ADDRESS);
		repeat (4) @(posedge pclk);
		check(boot_drive, 1'b0);
		t_regs();
		t_arb();
		t_mask();
		t_wake();
		t_ext();
		stop_test();
	end
endmodule
`default_nettype wire
